/* rtl/scl_pkg.sv */
// Constants, field layouts and carrier types for the level-2 snoopy cache controller.
// Assumes one 40 MHz clock and a host that owns the register port and the bus wiring.
//
// Operation
// - Processor I/O references are never cached and always make a bus cycle.
// - After reset the cache acts as one single-entry snoopy cache until enabled.
// - Lines keep shared and dirty bits; unshared write hits make no bus traffic.
// - A write hit to a shared line starts a write-through on the bus.
// - A miss that displaces a dirty line first writes that line back.
// - Snooped read or write-through hits set shared and assert the shared response.
// - A snooped write that hits updates the local data entry.
// - A snooped read supplies data only when the hit line is dirty.
// - A processor read hit returns data within one processor cycle.
// - A miss is retried, victim handled, line filled; the reissue then hits.
// - A processor write hit updates the data store and sets the dirty bit.
// - The write-through is a masked octaword write with processor data and masks.
// - When a write-through ends, shared is loaded from the sampled shared response.
// - Clean victim: read at once, invalidate level-1, then write data, tag, shared.
// - Dirty victim: invalidate level-1, write victim back, then fill as clean.
// - A snooped write-through hit clears the local dirty bit.
// - Tags are readable by software; flushing forces victims by congruent reads.
// - The slot I/O window is split in two equal halves, one per processor.
// - The tag holds address bits 28 to 16; bits 15 to 4 index the cache.
// - A line updated from the system bus is invalidated in the level-1 cache.
// - The external cache enable is bit 26 of the interface control register.

package scl_pkg;

   localparam int IDX_W        = 12;
   localparam int TAG_W        = 13;
   localparam int ENT_W        = 15;
   localparam int LINES        = 4096;
   localparam int WORDS        = 16384;
   localparam int LW_AW        = 14;
   localparam int LW_LO        = 2;
   localparam int LW_HI        = 3;
   localparam int IDX_LO       = 4;
   localparam int IDX_HI       = 15;
   localparam int TAG_LO       = 16;
   localparam int TAG_HI       = 28;
   localparam int UNCACHED_BIT = 29;
   localparam int ENT_DIRTY    = 13;
   localparam int ENT_SHARED   = 14;
   localparam int SLOT_HALF    = 24;
   localparam int SLOT_LO      = 25;
   localparam int SLOT_W       = 7;
   localparam int CSR_ECE_BIT  = 26;

   localparam logic [7:0] OFS_CSR      = 8'h00;
   localparam logic [7:0] OFS_TAG_IDX  = 8'h04;
   localparam logic [7:0] OFS_TAG_DATA = 8'h08;
   localparam logic [7:0] OFS_LW_IDX   = 8'h0c;
   localparam logic [7:0] OFS_LW_DATA  = 8'h10;
   localparam logic [7:0] OFS_STATUS   = 8'h14;

   localparam logic [1:0] LANE_LAST = 2'h3;

   typedef enum logic [2:0] {
      MB_IO_RD, MB_IO_WR, MB_OCT_RD, MB_VIC_WR, MB_WT, MB_SUPPLY
   } scl_mbcmd_e;

   typedef enum logic [1:0] {SN_READ, SN_WT, SN_WRITE} scl_sncmd_e;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic        io;
      logic [31:0] addr;
      logic [31:0] wdata;
      logic [3:0]  bmask;
   } scl_cpu_req_s;

   typedef struct packed {
      logic         valid;
      scl_mbcmd_e   cmd;
      logic [31:0]  addr;
      logic [127:0] data;
      logic [15:0]  mask;
   } scl_mb_req_s;

   typedef struct packed {
      logic         valid;
      scl_sncmd_e   cmd;
      logic [31:0]  addr;
      logic [127:0] data;
      logic [15:0]  mask;
   } scl_snoop_s;

endpackage

/* rtl/scl_cache_ctrl.sv */
// Level-2 snoopy cache controller: processor port, system bus master and snoop ports.
// Assumes all inputs synchronous to clk and a bus that answers each request with mb_done.

`timescale 1ns/1ps
`default_nettype none

module scl_cache_ctrl (
   input  wire logic                  clk,
   input  wire logic                  reset_n,
   input  wire logic [7:0]            reg_addr,
   input  wire logic [31:0]           reg_wdata,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   output logic [31:0]                reg_rdata,
   input  wire scl_pkg::scl_cpu_req_s cpu_req,
   output logic                       cpu_ready,
   output logic                       cpu_ack,
   output logic                       cpu_retry,
   output logic [31:0]                cpu_rdata,
   output logic                       l1_inv,
   output logic [31:0]                l1_inv_addr,
   output scl_pkg::scl_mb_req_s       mb_req,
   input  wire logic                  mb_done,
   input  wire logic [127:0]          mb_rdata,
   input  wire logic                  mb_shared,
   input  wire scl_pkg::scl_snoop_s   snoop,
   output logic                       line_shared_response,
   input  wire logic                  proc_sel,
   input  wire logic [6:0]            slot_io_base,
   input  wire logic [31:0]           io_addr,
   output logic                       slot_io_hit
);
   import scl_pkg::*;

   typedef enum logic [3:0] {
      ST_IDLE, ST_IO, ST_WT, ST_VRD, ST_VWR, ST_FRD, ST_FWR, ST_SUPD, ST_SRD, ST_SSUP
   } scl_state_e;

   // ----------------------------------------------------------------
   // Storage and state
   // ----------------------------------------------------------------
   logic [ENT_W-1:0] tag_mem [LINES];
   logic [31:0]      dat_mem [WORDS];

   scl_state_e       state_reg;
   scl_cpu_req_s     rq_reg;
   scl_snoop_s       snp_reg;
   scl_mb_req_s      mb_reg;
   logic [127:0]     line_reg;
   logic [1:0]       cnt_reg;
   logic             shr_reg;
   logic             ece_reg;
   logic             se_valid_reg;
   logic [24:0]      se_addr_reg;
   logic             upd_pend_reg;
   logic             sup_pend_reg;
   logic [IDX_W-1:0] tag_idx_reg;
   logic [LW_AW-1:0] lw_idx_reg;
   logic             ack_reg;
   logic             retry_reg;
   logic [31:0]      rdata_reg;
   logic             inv_reg;
   logic [31:0]      inv_addr_reg;
   logic             shresp_reg;
   logic             slot_reg;
   logic [31:0]      reg_rdata_reg;

   // ----------------------------------------------------------------
   // Processor probe
   // ----------------------------------------------------------------
   wire [IDX_W-1:0] c_idx  = ece_reg ? cpu_req.addr[IDX_HI:IDX_LO] : '0;
   wire [ENT_W-1:0] c_ent  = tag_mem[c_idx];
   wire [1:0]       c_lane = cpu_req.addr[LW_HI:LW_LO];
   wire             c_hit  = ece_reg ? (c_ent[TAG_W-1:0] == cpu_req.addr[TAG_HI:TAG_LO])
                                     : (se_valid_reg && se_addr_reg == cpu_req.addr[TAG_HI:IDX_LO]);
   wire             c_dirty = ece_reg ? c_ent[ENT_DIRTY] : (se_valid_reg && c_ent[ENT_DIRTY]);
   wire             c_unc  = cpu_req.io | cpu_req.addr[UNCACHED_BIT];
   wire             c_take = cpu_req.valid & cpu_ready;
   wire             c_rhit = c_take & ~c_unc & c_hit & ~cpu_req.write;
   wire             c_whit = c_take & ~c_unc & c_hit & cpu_req.write;
   wire             c_miss = c_take & ~c_unc & ~c_hit;
   wire [15:0]      c_mask = 16'({12'h000, cpu_req.bmask} << {c_lane, 2'b00});
   wire [31:0]      c_vict = ece_reg ? {3'b000, c_ent[TAG_W-1:0], c_idx, 4'h0}
                                     : {3'b000, se_addr_reg, 4'h0};
   wire [31:0]      c_line = {cpu_req.addr[31:IDX_LO], 4'h0};

   wire [IDX_W-1:0] r_idx  = ece_reg ? rq_reg.addr[IDX_HI:IDX_LO] : '0;
   wire [ENT_W-1:0] r_ent  = tag_mem[r_idx];

   assign cpu_ready = (state_reg == ST_IDLE) & ~upd_pend_reg & ~sup_pend_reg;

   // ----------------------------------------------------------------
   // Snoop probe
   // ----------------------------------------------------------------
   wire [IDX_W-1:0] s_idx = ece_reg ? snoop.addr[IDX_HI:IDX_LO] : '0;
   wire [ENT_W-1:0] s_ent = tag_mem[s_idx];
   wire             s_hit = snoop.valid & ~snoop.addr[UNCACHED_BIT] &
                            (ece_reg ? (s_ent[TAG_W-1:0] == snoop.addr[TAG_HI:TAG_LO])
                                     : (se_valid_reg && se_addr_reg == snoop.addr[TAG_HI:IDX_LO]));
   wire             s_rd  = s_hit & (snoop.cmd == SN_READ);
   wire             s_wt  = s_hit & (snoop.cmd == SN_WT);
   wire             s_wr  = s_hit & (snoop.cmd == SN_WRITE);
   wire             s_shr = s_rd | s_wt;
   wire             s_upd = s_wt | s_wr;
   wire             s_sup = s_rd & s_ent[ENT_DIRTY];
   wire [ENT_W-1:0] s_new = {1'b1, s_ent[ENT_DIRTY] & ~s_wt, s_ent[TAG_W-1:0]};

   wire [IDX_W-1:0] p_idx = ece_reg ? snp_reg.addr[IDX_HI:IDX_LO] : '0;

   // ----------------------------------------------------------------
   // Tag and data write ports
   // ----------------------------------------------------------------
   wire             fwr_end = (state_reg == ST_FWR) & (cnt_reg == LANE_LAST);
   wire             wt_end  = (state_reg == ST_WT) & mb_done;
   wire             rg_tag  = reg_wr & (reg_addr == OFS_TAG_DATA);
   wire             rg_lw   = reg_wr & (reg_addr == OFS_LW_DATA);
   wire             tw_en   = c_whit | wt_end | fwr_end | rg_tag;
   wire [IDX_W-1:0] tw_idx  = c_whit ? c_idx : ((wt_end | fwr_end) ? r_idx : tag_idx_reg);
   wire [ENT_W-1:0] tw_val  =
      c_whit  ? {c_ent[ENT_SHARED], 1'b1, c_ent[TAG_W-1:0]} :
      wt_end  ? {mb_shared, r_ent[ENT_DIRTY], r_ent[TAG_W-1:0]} :
      fwr_end ? {shr_reg, 1'b0, rq_reg.addr[TAG_HI:TAG_LO]} :
                reg_wdata[ENT_W-1:0];

   wire             dw_fill = (state_reg == ST_FWR) | (state_reg == ST_SUPD);
   wire             dw_en   = c_whit | dw_fill | rg_lw;
   wire [LW_AW-1:0] dw_addr = c_whit ? {c_idx, c_lane} :
                              (state_reg == ST_FWR)  ? {r_idx, cnt_reg} :
                              (state_reg == ST_SUPD) ? {p_idx, cnt_reg} : lw_idx_reg;
   wire [31:0]      dw_data = c_whit ? cpu_req.wdata :
                              dw_fill ? line_reg[{cnt_reg, 5'h00} +: 32] : reg_wdata;
   wire [3:0]       dw_be   = c_whit ? cpu_req.bmask :
                              (state_reg == ST_SUPD) ? snp_reg.mask[{cnt_reg, 2'b00} +: 4] :
                              4'hf;

   wire [IDX_W-1:0] rd_idx  = (state_reg == ST_SRD) ? p_idx : r_idx;
   wire [31:0]      rd_word = dat_mem[{rd_idx, cnt_reg}];

   always_ff @(posedge clk) begin
      if (tw_en) begin
         tag_mem[tw_idx] <= tw_val;
      end
      if (s_shr) begin
         tag_mem[s_idx] <= s_new;
      end
   end

   always_ff @(posedge clk) begin
      if (dw_en) begin
         for (int b = 0; b < 4; b++) begin
            if (dw_be[b]) begin
               dat_mem[dw_addr][b*8 +: 8] <= dw_data[b*8 +: 8];
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Control sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg    <= ST_IDLE;
         rq_reg       <= '0;
         mb_reg       <= '0;
         line_reg     <= '0;
         cnt_reg      <= '0;
         shr_reg      <= 1'b0;
         se_valid_reg <= 1'b0;
         se_addr_reg  <= '0;
         ack_reg      <= 1'b0;
         retry_reg    <= 1'b0;
         rdata_reg    <= '0;
         inv_reg      <= 1'b0;
         inv_addr_reg <= '0;
      end else begin
         ack_reg   <= 1'b0;
         retry_reg <= 1'b0;
         inv_reg   <= 1'b0;
         case (state_reg)
            ST_IDLE: begin
               cnt_reg <= '0;
               if (upd_pend_reg) begin
                  inv_reg      <= 1'b1;
                  inv_addr_reg <= {snp_reg.addr[31:IDX_LO], 4'h0};
                  line_reg     <= snp_reg.data;
                  state_reg    <= ST_SUPD;
               end else if (sup_pend_reg) begin
                  state_reg <= ST_SRD;
               end else if (c_take) begin
                  rq_reg <= cpu_req;
                  if (c_unc) begin
                     mb_reg    <= '{1'b1, cpu_req.write ? MB_IO_WR : MB_IO_RD,
                                    cpu_req.addr, {4{cpu_req.wdata}}, c_mask};
                     state_reg <= ST_IO;
                  end else if (c_rhit) begin
                     rdata_reg <= dat_mem[{c_idx, c_lane}];
                     ack_reg   <= 1'b1;
                  end else if (c_whit && c_ent[ENT_SHARED]) begin
                     mb_reg    <= '{1'b1, MB_WT, c_line, {4{cpu_req.wdata}}, c_mask};
                     state_reg <= ST_WT;
                  end else if (c_whit) begin
                     ack_reg <= 1'b1;
                  end else begin
                     retry_reg    <= 1'b1;
                     inv_reg      <= 1'b1;
                     inv_addr_reg <= c_vict;
                     if (c_dirty) begin
                        mb_reg.addr <= c_vict;
                        state_reg   <= ST_VRD;
                     end else begin
                        mb_reg    <= '{1'b1, MB_OCT_RD, c_line, 128'h0, 16'h0000};
                        state_reg <= ST_FRD;
                     end
                  end
               end
            end
            ST_IO: begin
               if (mb_done) begin
                  mb_reg.valid <= 1'b0;
                  rdata_reg    <= mb_rdata[{rq_reg.addr[LW_HI:LW_LO], 5'h00} +: 32];
                  ack_reg      <= 1'b1;
                  state_reg    <= ST_IDLE;
               end
            end
            ST_WT: begin
               if (mb_done) begin
                  mb_reg.valid <= 1'b0;
                  ack_reg      <= 1'b1;
                  state_reg    <= ST_IDLE;
               end
            end
            ST_VRD, ST_SRD: begin
               line_reg[{cnt_reg, 5'h00} +: 32] <= rd_word;
               cnt_reg <= cnt_reg + 2'h1;
               if (cnt_reg == LANE_LAST) begin
                  mb_reg.valid <= 1'b1;
                  mb_reg.mask  <= 16'hffff;
                  // The last lane is still on its way into line_reg, so take it from the store.
                  mb_reg.data  <= {rd_word, line_reg[95:0]};
                  if (state_reg == ST_VRD) begin
                     mb_reg.cmd <= MB_VIC_WR;
                     state_reg  <= ST_VWR;
                  end else begin
                     mb_reg.cmd  <= MB_SUPPLY;
                     mb_reg.addr <= {snp_reg.addr[31:IDX_LO], 4'h0};
                     state_reg   <= ST_SSUP;
                  end
               end
            end
            ST_VWR, ST_SSUP: begin
               mb_reg.data <= line_reg;
               if (mb_done) begin
                  mb_reg.valid <= 1'b0;
                  if (state_reg == ST_VWR) begin
                     mb_reg    <= '{1'b1, MB_OCT_RD, {rq_reg.addr[31:IDX_LO], 4'h0},
                                    128'h0, 16'h0000};
                     state_reg <= ST_FRD;
                  end else begin
                     state_reg <= ST_IDLE;
                  end
               end
            end
            ST_FRD: begin
               if (mb_done) begin
                  mb_reg.valid <= 1'b0;
                  line_reg     <= mb_rdata;
                  shr_reg      <= mb_shared;
                  cnt_reg      <= '0;
                  state_reg    <= ST_FWR;
               end
            end
            ST_FWR, ST_SUPD: begin
               cnt_reg <= cnt_reg + 2'h1;
               if (cnt_reg == LANE_LAST) begin
                  if (state_reg == ST_FWR && !ece_reg) begin
                     se_addr_reg  <= rq_reg.addr[TAG_HI:IDX_LO];
                     se_valid_reg <= 1'b1;
                  end
                  state_reg <= ST_IDLE;
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // Snoop work is queued here; a new snoop in the clearing cycle wins.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         snp_reg      <= '0;
         upd_pend_reg <= 1'b0;
         sup_pend_reg <= 1'b0;
         shresp_reg   <= 1'b0;
      end else begin
         shresp_reg <= s_shr;
         if (state_reg == ST_SUPD && cnt_reg == LANE_LAST) begin
            upd_pend_reg <= 1'b0;
         end
         if (state_reg == ST_SSUP && mb_done) begin
            sup_pend_reg <= 1'b0;
         end
         if (s_upd | s_sup) begin
            snp_reg      <= snoop;
            upd_pend_reg <= s_upd;
            sup_pend_reg <= s_sup;
         end
      end
   end

   // ----------------------------------------------------------------
   // Register port and slot window decode
   // ----------------------------------------------------------------
   wire        slot_dec = (io_addr[31:SLOT_LO] == slot_io_base) &
                          (io_addr[SLOT_HALF] == proc_sel);
   wire [31:0] csr_rd   = 32'(ece_reg) << CSR_ECE_BIT;
   wire [31:0] stat_rd  = {28'h0000000, se_valid_reg, sup_pend_reg, upd_pend_reg,
                           state_reg != ST_IDLE};
   wire [31:0] rd_mux   =
      (reg_addr == OFS_CSR)      ? csr_rd :
      (reg_addr == OFS_TAG_IDX)  ? {20'h00000, tag_idx_reg} :
      (reg_addr == OFS_TAG_DATA) ? {17'h00000, tag_mem[tag_idx_reg]} :
      (reg_addr == OFS_LW_IDX)   ? {18'h00000, lw_idx_reg} :
      (reg_addr == OFS_LW_DATA)  ? dat_mem[lw_idx_reg] :
      (reg_addr == OFS_STATUS)   ? stat_rd : 32'h00000000;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ece_reg       <= 1'b0;
         tag_idx_reg   <= '0;
         lw_idx_reg    <= '0;
         reg_rdata_reg <= '0;
         slot_reg      <= 1'b0;
      end else begin
         slot_reg      <= slot_dec;
         reg_rdata_reg <= reg_rd ? rd_mux : 32'h00000000;
         if (reg_wr && reg_addr == OFS_CSR) begin
            ece_reg <= reg_wdata[CSR_ECE_BIT];
         end
         if (reg_wr && reg_addr == OFS_TAG_IDX) begin
            tag_idx_reg <= reg_wdata[IDX_W-1:0];
         end
         if (reg_wr && reg_addr == OFS_LW_IDX) begin
            lw_idx_reg <= reg_wdata[LW_AW-1:0];
         end
      end
   end

   assign reg_rdata            = reg_rdata_reg;
   assign cpu_ack              = ack_reg;
   assign cpu_retry            = retry_reg;
   assign cpu_rdata            = rdata_reg;
   assign l1_inv               = inv_reg;
   assign l1_inv_addr          = inv_addr_reg;
   assign mb_req               = mb_reg;
   assign line_shared_response = shresp_reg;
   assign slot_io_hit          = slot_reg;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   io_bus_cycle_a: assert property (c_take && c_unc |=> mb_req.valid &&
      (mb_req.cmd == MB_IO_RD || mb_req.cmd == MB_IO_WR))
      else $error("I/O reference made no bus cycle");
   read_hit_ack_a: assert property (c_rhit |=> cpu_ack && !cpu_retry)
      else $error("Read hit not answered in one cycle");
   local_write_a: assert property (c_whit && !c_ent[ENT_SHARED] |=>
      cpu_ack && !mb_req.valid)
      else $error("Unshared write hit went to the bus");
   shared_wt_a: assert property (c_whit && c_ent[ENT_SHARED] |=>
      mb_req.valid && mb_req.cmd == MB_WT && mb_req.mask != 16'h0000)
      else $error("Shared write hit made no write-through");
   miss_retry_a: assert property (c_miss |=> cpu_retry && l1_inv)
      else $error("Miss not retried with level-1 invalidate");
   victim_wr_a: assert property (c_miss && c_dirty |=>
      !mb_req.valid [*4] ##1 mb_req.valid && mb_req.cmd == MB_VIC_WR)
      else $error("Dirty victim not written back");
   wt_shared_a: assert property (wt_end |=> tag_mem[$past(r_idx)][ENT_SHARED] ==
      $past(mb_shared))
      else $error("Shared bit not loaded after write-through");
   snoop_resp_a: assert property (s_shr |=> line_shared_response)
      else $error("Snoop hit gave no shared response");
   snoop_upd_a: assert property (s_upd |-> ##[1:20] l1_inv)
      else $error("Snoop update did not invalidate level-1");
   supply_dirty_a: assert property ($rose(mb_req.valid) &&
      mb_req.cmd == MB_SUPPLY |-> $past(state_reg) == ST_SRD)
      else $error("Supply without dirty snoop hit");

   cov_read_hit_c:   cover property (c_rhit);
   cov_dirty_miss_c: cover property (c_miss && c_dirty);
   cov_wt_c:         cover property (wt_end);
   cov_supply_c:     cover property (s_sup);

endmodule // scl_cache_ctrl

`default_nettype wire

/* test/scl_bus_model.sv */
// System bus memory model facing the cache controller.
// Assumes one held request at a time, ended by a one-cycle done.
`timescale 1ns/1ps
`default_nettype none
module scl_bus_model (
   input  wire logic                 clk,
   input  wire logic                 reset_n,
   input  wire scl_pkg::scl_mb_req_s mb_req,
   input  wire logic                 slow,
   input  wire logic                 share_in,
   output logic                      mb_done,
   output logic [127:0]              mb_rdata,
   output logic                      mb_shared
);
   import scl_pkg::*;
   logic [1:0]  wait_reg;
   wire  [31:0] base = mb_req.addr & 32'hffff_fff0;
   // Lane n reads back as the octaword address plus n; idle data toggles.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wait_reg <= 2'h0;
         mb_done <= 1'b0;
         mb_rdata <= '0;
         mb_shared <= 1'b0;
      end else begin
         mb_done <= mb_req.valid && !mb_done && wait_reg == {slow, slow};
         wait_reg <= (mb_req.valid && !mb_done) ? wait_reg + 2'h1 : 2'h0;
         mb_rdata <= mb_req.valid ? {base + 32'h3, base + 32'h2, base + 32'h1, base} : ~mb_rdata;
         mb_shared <= share_in;
      end
   end
endmodule // scl_bus_model
`default_nettype wire

/* test/tb_top.sv */
// Bench for the cache controller: init, misses, hits, snoops, I/O and slot decode.
// Assumes scl_bus_model stands on the system bus side.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import scl_pkg::*;
   logic clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, slow = 0, share = 0, proc_sel = 0;
   logic cpu_ready, cpu_ack, cpu_retry, l1_inv, mb_done, mb_shared, line_shared_response;
   logic slot_io_hit, rt;
   logic [6:0] slot_io_base = 0;
   logic [7:0] reg_addr = 0;
   logic [15:0] wm;
   logic [31:0] reg_wdata = 0, io_addr = 0, lfsr = 32'h19c1, reg_rdata, cpu_rdata, l1_inv_addr, a, d, x;
   logic [127:0] mb_rdata, sd;
   scl_cpu_req_s cpu_req = '0;
   scl_mb_req_s mb_req;
   scl_snoop_s snoop = '0;
   scl_mbcmd_e q[$];
   int err_total, checks_done, cyc, ninv, n0, lat;
   scl_cache_ctrl i_dut (.clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .cpu_req, .cpu_ready, .cpu_ack, .cpu_retry, .cpu_rdata, .l1_inv, .l1_inv_addr, .mb_req,
      .mb_done, .mb_rdata, .mb_shared, .snoop, .line_shared_response, .proc_sel,
      .slot_io_base, .io_addr, .slot_io_hit);
   scl_bus_model i_bus (.clk, .reset_n, .mb_req, .slow, .share_in(share), .mb_done,
      .mb_rdata, .mb_shared);
   function automatic logic [31:0] nx(logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic chk(string s, logic [31:0] e, logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic rw(logic [7:0] ad, logic [31:0] v);
      @(posedge clk);
      reg_addr <= ad;
      reg_wdata <= v;
      reg_wr <= 1'b1;
   endtask
   task automatic rr(logic [7:0] ad, output logic [31:0] v);
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      reg_addr <= ad;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask
   task automatic tg(string s, logic [31:0] e);
      rw(OFS_TAG_IDX, {20'h0, a[15:4]});
      rr(OFS_TAG_DATA, x);
      chk(s, e | a[28:16], x);
   endtask
   task automatic cpu(logic w, logic [31:0] ad);
      @(posedge clk);
      cpu_req <= '{1'b1, w, ad[29], ad, d, 4'hf};
      do @(negedge clk); while (!cpu_ready);
      @(posedge clk);
      cpu_req.valid <= 1'b0;
      lat = 0;
      #1;
      while (!cpu_ack && !cpu_retry && lat < 300) begin
         @(posedge clk);
         #1 lat++;
      end
      rt = cpu_retry;
      x = cpu_rdata;
   endtask
   task automatic sn(scl_sncmd_e c);
      @(posedge clk);
      snoop <= '{1'b1, c, a, {4{d}}, 16'hffff};
      @(posedge clk);
      snoop.valid <= 1'b0;
      #1 chk("shresp", c != SN_WRITE, line_shared_response);
   endtask
   task automatic test_done();
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial begin
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (mb_req.valid && mb_done) q.push_back(mb_req.cmd);
      if (mb_req.valid && mb_req.cmd == MB_WT) wm <= mb_req.mask;
      if (mb_req.valid && mb_done && mb_req.cmd == MB_SUPPLY) sd <= mb_req.data;
      if (l1_inv) ninv++;
      if (++cyc > 60000) begin
         err_total++;
         test_done();
      end
   end
   initial begin
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      chk("ready", 1, cpu_ready);
      rr(OFS_CSR, x);
      chk("csr", 0, x);
      a = 32'h0001_2344;
      cpu(0, a);
      chk("se_miss", 1, rt);
      cpu(0, a);
      chk("se_hit", 32'h0001_2341, x);
      rw(OFS_CSR, 32'h1 << CSR_ECE_BIT);
      rr(OFS_CSR, x);
      chk("csr", 32'h1 << CSR_ECE_BIT, x);
      for (int k = 0; k < 3; k++) for (int i = 0; i < (k == 1 ? WORDS : LINES); i++) begin
         rw(k == 1 ? OFS_LW_IDX : OFS_TAG_IDX, 32'(i));
         rw(k == 1 ? OFS_LW_DATA : OFS_TAG_DATA, k == 2 ? 32'h6000 : 32'h0);
      end
      rr(OFS_STATUS, x);
      chk("idle", 32'h8, x);
      for (int it = 0; it < 2; it++) begin
         lfsr = nx(lfsr);
         a = (lfsr & 32'h1fff_fffc) | 32'h0001_0000;
         d = nx(lfsr);
         slow <= lfsr[0];
         q.delete();
         n0 = ninv;
         cpu(0, a);
         chk("miss", 1, rt);
         chk("invad", a & 32'h0000_fff0, l1_inv_addr);
         cpu(0, a);
         chk("lat", 0, lat);
         chk("fill", (a & 32'hffff_fff0) + a[3:2], x);
         chk("vic", MB_VIC_WR, q[0]);
         chk("rd", MB_OCT_RD, q[1]);
         chk("inv", n0 + 1, ninv);
         q.delete();
         cpu(1, a);
         chk("wlat", 0, lat);
         chk("nobus", 0, q.size());
         tg("dirty", 32'h2000);
         sn(SN_READ);
         repeat (30) @(posedge clk);
         chk("supply", MB_SUPPLY, q[0]);
         chk("sdat", d, sd[{a[3:2], 5'h00} +: 32]);
         q.delete();
         share <= lfsr[4];
         cpu(1, a);
         chk("wt", MB_WT, q[0]);
         chk("mask", 16'hf << (4 * a[3:2]), wm);
         tg("unshr", 32'h2000 | (32'(lfsr[4]) << 14));
         share <= 1'b0;
         d = ~d;
         n0 = ninv;
         sn(SN_WT);
         tg("snwt", 32'h4000);
         chk("sninv", n0 + 1, ninv);
         cpu(0, a);
         chk("upd", d, x);
         d = ~d;
         sn(SN_WRITE);
         cpu(0, a);
         chk("snwr", d, x);
         q.delete();
         cpu(0, a | 32'h2000_0000);
         chk("io", MB_IO_RD, q[0]);
         chk("iord", ((a | 32'h2000_0000) & 32'hffff_fff0) + a[3:2], x);
         proc_sel <= lfsr[2];
         slot_io_base <= lfsr[9:3];
         io_addr <= {lfsr[9:3] ^ {6'h0, lfsr[10]}, lfsr[1], d[23:0]};
         repeat (2) @(posedge clk);
         #1 chk("slot", io_addr[31:25] == slot_io_base && io_addr[24] == proc_sel, slot_io_hit);
         $display("pass %0d done", it);
      end
      cpu(1, a);
      q.delete();
      cpu(0, a ^ 32'h0001_0000);
      repeat (30) @(posedge clk);
      chk("flush", MB_VIC_WR, q[0]);
      rw(OFS_CSR, 32'h0);
      rr(OFS_CSR, x);
      chk("off", 0, x);
      $display("flush done");
      test_done();
   end
endmodule // tb_top
`default_nettype wire
